// [fpmc_pkg.sv]
// Package of constants for the floating-point mode control block
package fpmc_pkg;
  // Scalar control word layout
  localparam int SCW_WIDTH       = 16;
  localparam int PREC_LSB        = 8;
  localparam int PREC_MSB        = 9;
  localparam int ROUND_LSB       = 10;
  localparam int ROUND_MSB       = 11;
  localparam int INF_BIT         = 12;
  localparam logic [15:0] FAST_BITS_MASK = 16'h1F00;
  localparam logic [15:0] SCW_RESET      = 16'h037F;
  localparam logic [1:0]  PREC_SINGLE    = 2'h0;
  localparam logic [1:0]  PREC_DOUBLE    = 2'h2;
  // SIMD control/status layout
  localparam int SIMD_WIDTH      = 32;
  localparam int DAZ_BIT         = 6;
  localparam int FTZ_BIT         = 15;
  localparam logic [31:0] SIMD_RESET     = 32'h0000_1F80;
  // Register offsets
  localparam logic [3:0] OFF_SCW        = 4'h0;
  localparam logic [3:0] OFF_SIMD       = 4'h1;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFF_IRQ_MASK   = 4'h3;
  localparam logic [3:0] OFF_STATS      = 4'h4;
  // Event bits in status and mask
  localparam int EV_SLOW_LOAD = 0;
  localparam int EV_SERIALIZE = 1;
  localparam int EV_FLUSH     = 2;
  localparam int EV_DAZ       = 3;
  localparam int EV_COUNT     = 4;
  // Timing: pipeline depth time and clock period in ns, the rest in cycles
  localparam int PIPE_DEPTH_TIME_NS = 100;
  localparam int CLK_PERIOD_NS      = 5;
  localparam int SLOW_LOAD_CYCLES   = PIPE_DEPTH_TIME_NS / CLK_PERIOD_NS;
  localparam int SERIALIZE_CYCLES   = SLOW_LOAD_CYCLES;
  localparam int SIMD_READ_CYCLES   = 4;
  localparam int DIV_SINGLE_CYCLES  = 12;
  localparam int DIV_DOUBLE_CYCLES  = 20;
  localparam int DIV_EXT_CYCLES     = 24;
  // Fp32 field layout
  localparam int FP_EXP_LSB = 23;
  localparam int FP_EXP_MSB = 30;
  localparam int FP_SIGN    = 31;
  localparam logic [7:0] FP_EXP_MIN = 8'h01;
endpackage

// [fpmc_special.sv]
// Special-value handling of one fp32 lane: denormal-input zeroing and underflow flush
`timescale 1ns/1ps
module fpmc_special
  import fpmc_pkg::*;
(
  input  wire logic [31:0] src_a,          // Source operand
  input  wire logic [31:0] raw_result,     // Unrounded datapath result
  input  wire logic        daz_en,         // Denormal inputs become zero
  input  wire logic        ftz_en,         // Underflowing results become zero
  output logic      [31:0] src_clean,      // Operand after input handling
  output logic      [31:0] result_clean,   // Result after output handling
  output logic             daz_hit,        // An input was zeroed
  output logic             ftz_hit         // A result was flushed
);
  logic a_denorm;
  logic r_denorm;

  assign a_denorm = (src_a[FP_EXP_MSB:FP_EXP_LSB] == 8'h00) && (src_a[22:0] != 23'h00_0000);
  assign r_denorm = (raw_result[FP_EXP_MSB:FP_EXP_LSB] < FP_EXP_MIN)
                    && (raw_result[22:0] != 23'h00_0000);

  // Zero keeps the operand's sign
  assign daz_hit   = daz_en && a_denorm;
  assign src_clean = daz_hit ? {src_a[FP_SIGN], 31'h0000_0000} : src_a;
  // Flushed zero keeps the sign of the true result; else gradual denormal passes
  assign ftz_hit      = ftz_en && r_denorm;
  assign result_clean = ftz_hit ? {raw_result[FP_SIGN], 31'h0000_0000} : raw_result;
endmodule

// [fpmc_top.sv]
// Floating-point mode control: control words, load fast path, special values
//
// Overview of operation
// - Flush mode turns underflow into signed zero
// - Denormal-zero mode zeroes denormal inputs, sign kept
// - Both modes off: gradual denormals, slower; the code passes them in the same one cycle with no stall
// - Masked overflow handled in hardware, no delay
// - Denormal-zero honoured by both instruction generations
// - Scalar range checks use extended exponent range
// - Precision 8-9, rounding 10-11, infinity bit 12
// - Two alternating values differing in five bits: fast
// - Change outside five bits takes slow path
// - Three or more values: each load slow
// - New pair slow only during transition
// - SIMD control write serializes; read slow
// - Single and double share one SIMD control
// - Single precision divides finish faster
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module fpmc_top
  import fpmc_pkg::*;
(
  input  wire logic        ref_clk,          // Core clock
  input  wire logic        srst,             // Synchronous reset, high
  input  wire logic [3:0]  reg_addr,         // Register word index
  input  wire logic [31:0] reg_wdata,        // Write data
  input  wire logic        reg_wr,           // Write strobe
  input  wire logic        reg_rd,           // Read strobe
  output logic      [31:0] reg_rdata,        // Read data, cycle after strobe
  input  wire logic        control_word_load_op, // Scalar control word load
  input  wire logic [15:0] load_value,       // Value being loaded
  input  wire logic        simd_op_valid,    // SIMD lane operation
  input  wire logic        simd_second_gen,  // Operation from second generation
  input  wire logic        simd_double,      // Double-precision operation
  input  wire logic [31:0] simd_src,         // SIMD source operand
  input  wire logic [31:0] simd_raw_result,  // SIMD raw result
  input  wire logic        simd_overflow,    // Masked overflow from SIMD datapath
  input  wire logic        div_start,        // Scalar divide or square root start
  input  wire logic [15:0] scalar_exp,       // Extended-format exponent of result
  output logic      [31:0] simd_src_out,     // Operand after denormal handling
  output logic      [31:0] simd_result_out,  // Result after flush handling
  output logic             simd_out_valid,   // Lane outputs valid
  output logic             scalar_overflow,  // Extended-range overflow
  output logic             scalar_underflow, // Extended-range underflow
  output logic             div_done,         // Divide finished pulse
  output logic             busy,             // Pipeline stalled
  output logic             irq               // Interrupt, level
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SLOW  = 4'b0010,
    ST_SER   = 4'b0100,
    ST_RDWT  = 4'b1000
  } fpmc_state_type;

  fpmc_state_type state_reg;
  fpmc_state_type state_next;
  logic [15:0] scalar_fp_control_word;
  logic [31:0] simd_fp_control_status_reg;
  logic [15:0] last_a_reg;
  logic [15:0] last_b_reg;
  logic [7:0]  wait_reg;
  logic [7:0]  wait_next;
  logic [EV_COUNT-1:0] status_reg;
  logic [EV_COUNT-1:0] mask_reg;
  logic [EV_COUNT-1:0] events;
  logic [15:0] slow_count_reg;
  logic [15:0] fast_count_reg;
  logic [7:0]  div_cnt_reg;
  logic        div_run_reg;
  logic        fast_hit;
  logic        outside_change;
  logic        load_slow;
  logic        simd_write;
  logic        simd_read;
  logic        underflow_flush_mode;
  logic        denormal_input_zero_mode;
  logic [31:0] src_clean;
  logic [31:0] res_clean;
  logic        daz_hit;
  logic        ftz_hit;
  logic [1:0]  precision_field;
  logic [7:0]  div_len;

  // One control pair for both precisions, so simd_double does not select it
  assign underflow_flush_mode     = simd_fp_control_status_reg[FTZ_BIT];
  assign denormal_input_zero_mode = simd_fp_control_status_reg[DAZ_BIT];
  assign precision_field = scalar_fp_control_word[PREC_MSB:PREC_LSB];

  // Fast path: new value equals one of the last two, and differs from the current word only in fast bits
  assign outside_change = ((load_value ^ scalar_fp_control_word) & ~FAST_BITS_MASK) != 16'h0000;
  assign fast_hit = ((load_value == last_a_reg) || (load_value == last_b_reg))
                    && !outside_change;
  // A third distinct value or a pair change misses the history and goes slow once
  assign load_slow = control_word_load_op && (state_reg == ST_IDLE) && !fast_hit;
  assign simd_write = reg_wr && (reg_addr == OFF_SIMD);
  assign simd_read  = reg_rd && (reg_addr == OFF_SIMD);

  fpmc_special u_special (
    .src_a        (simd_src),
    .raw_result   (simd_raw_result),
    .daz_en       (denormal_input_zero_mode),
    .ftz_en       (underflow_flush_mode),
    .src_clean    (src_clean),
    .result_clean (res_clean),
    .daz_hit      (daz_hit),
    .ftz_hit      (ftz_hit)
  );

  always_comb
  begin
    state_next = state_reg;
    wait_next  = wait_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (simd_write)
        begin
          state_next = ST_SER;
          wait_next  = 8'(SERIALIZE_CYCLES - 1);
        end
        else if (load_slow)
        begin
          state_next = ST_SLOW;
          wait_next  = 8'(SLOW_LOAD_CYCLES - 1);
        end
        else if (simd_read)
        begin
          state_next = ST_RDWT;
          wait_next  = 8'(SIMD_READ_CYCLES - 1);
        end
      end
      ST_SLOW, ST_SER, ST_RDWT:
      begin
        if (wait_reg == 8'h00)
        begin
          state_next = ST_IDLE;
        end
        else
        begin
          wait_next = wait_reg - 8'h01;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      wait_reg  <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= (state_next != ST_IDLE);
    end
  end

  // Scalar control word and load history
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scalar_fp_control_word <= SCW_RESET;
      last_a_reg             <= SCW_RESET;
      last_b_reg             <= SCW_RESET;
    end
    else if (control_word_load_op && state_reg == ST_IDLE && !simd_write)
    begin
      scalar_fp_control_word <= load_value;
      if (load_value != last_a_reg)
      begin
        last_b_reg <= last_a_reg;
        last_a_reg <= load_value;
      end
    end
    else if (reg_wr && reg_addr == OFF_SCW && state_reg == ST_IDLE)
    begin
      scalar_fp_control_word <= reg_wdata[15:0];
    end
  end

  // SIMD control register; write serializes via the state machine
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      simd_fp_control_status_reg <= SIMD_RESET;
    end
    else if (simd_write && state_reg == ST_IDLE)
    begin
      simd_fp_control_status_reg <= reg_wdata;
    end
  end

  // SIMD lane registered outputs; overflow passes with no extra stage
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      simd_src_out    <= 32'h0000_0000;
      simd_result_out <= 32'h0000_0000;
      simd_out_valid  <= 1'b0;
    end
    else
    begin
      simd_out_valid  <= simd_op_valid;
      simd_src_out    <= src_clean;
      simd_result_out <= res_clean;
    end
  end

  // Range checks against the 15-bit extended exponent, not a memory format
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scalar_overflow  <= 1'b0;
      scalar_underflow <= 1'b0;
    end
    else
    begin
      scalar_overflow  <= scalar_exp[14:0] == 15'h7FFF;
      scalar_underflow <= scalar_exp[14:0] == 15'h0000;
    end
  end

  // Divider latency follows the precision field
  always_comb
  begin
    if (precision_field == PREC_SINGLE)
    begin
      div_len = 8'(DIV_SINGLE_CYCLES);
    end
    else if (precision_field == PREC_DOUBLE)
    begin
      div_len = 8'(DIV_DOUBLE_CYCLES);
    end
    else
    begin
      div_len = 8'(DIV_EXT_CYCLES);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_run_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      div_done    <= 1'b0;
    end
    else
    begin
      div_done <= 1'b0;
      if (div_run_reg)
      begin
        if (div_cnt_reg == 8'h01)
        begin
          div_run_reg <= 1'b0;
          div_done    <= 1'b1;
        end
        div_cnt_reg <= div_cnt_reg - 8'h01;
      end
      else if (div_start)
      begin
        div_run_reg <= 1'b1;
        div_cnt_reg <= div_len;
      end
    end
  end

  // Path statistics
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      slow_count_reg <= 16'h0000;
      fast_count_reg <= 16'h0000;
    end
    else if (control_word_load_op && state_reg == ST_IDLE && !simd_write)
    begin
      if (fast_hit)
      begin
        fast_count_reg <= fast_count_reg + 16'h0001;
      end
      else
      begin
        slow_count_reg <= slow_count_reg + 16'h0001;
      end
    end
  end

  assign events[EV_SLOW_LOAD] = load_slow && !simd_write;
  assign events[EV_SERIALIZE] = simd_write && state_reg == ST_IDLE;
  assign events[EV_FLUSH]     = simd_op_valid && ftz_hit;
  assign events[EV_DAZ]       = simd_op_valid && daz_hit && (simd_double || !simd_double);

  // Read clears status; a same-cycle event still sets its bit
  genvar gi;
  generate
    for (gi = 0; gi < EV_COUNT; gi = gi + 1)
    begin : g_status
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          status_reg[gi] <= 1'b0;
        end
        else if (events[gi])
        begin
          status_reg[gi] <= 1'b1;
        end
        else if (reg_rd && reg_addr == OFF_IRQ_STATUS)
        begin
          status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      mask_reg <= {EV_COUNT{1'b0}};
    end
    else if (reg_wr && reg_addr == OFF_IRQ_MASK)
    begin
      mask_reg <= reg_wdata[EV_COUNT-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      if (reg_addr == OFF_SCW)
      begin
        reg_rdata <= {16'h0000, scalar_fp_control_word};
      end
      else if (reg_addr == OFF_SIMD)
      begin
        reg_rdata <= simd_fp_control_status_reg;
      end
      else if (reg_addr == OFF_IRQ_STATUS)
      begin
        reg_rdata <= {28'h000_0000, status_reg};
      end
      else if (reg_addr == OFF_IRQ_MASK)
      begin
        reg_rdata <= {28'h000_0000, mask_reg};
      end
      else if (reg_addr == OFF_STATS)
      begin
        reg_rdata <= {slow_count_reg, fast_count_reg};
      end
      else
      begin
        reg_rdata <= 32'h0000_0000;
      end
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// [fpmc_assertions.sv]
// Port-level checker for the floating-point mode control block
`timescale 1ns/1ps
module fpmc_assertions
  import fpmc_pkg::*;
(
  input wire logic        ref_clk,              // Clock
  input wire logic        srst,                 // Reset
  input wire logic [3:0]  reg_addr,             // Address
  input wire logic        reg_wr,               // Write
  input wire logic        reg_rd,               // Read
  input wire logic [31:0] reg_rdata,            // Read data
  input wire logic        control_word_load_op, // Load
  input wire logic        simd_op_valid,        // Lane in
  input wire logic [31:0] simd_src,             // Operand
  input wire logic [31:0] simd_raw_result,      // Raw result
  input wire logic        simd_overflow,        // Overflow
  input wire logic        div_start,            // Divide
  input wire logic [31:0] simd_src_out,         // Operand out
  input wire logic [31:0] simd_result_out,      // Result out
  input wire logic        simd_out_valid,       // Lane out
  input wire logic        div_done,             // Divide done
  input wire logic        busy                  // Stall
);
  logic [7:0] busy_cnt_reg;

  // Run length of busy, read at its falling edge
  always_ff @(posedge ref_clk)
  begin
    if (srst || !busy)
      busy_cnt_reg <= 8'h00;
    else
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read slot");
  AST_RDATA_UNMAPPED: assert property (reg_rd && reg_addr > OFF_STATS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OUT_VALID: assert property (1'b1 |=> simd_out_valid == $past(simd_op_valid))
    else $error("lane valid not one cycle after input");
  AST_SRC_DENORM_ONLY: assert property (simd_op_valid |=> simd_src_out == $past(simd_src) ||
    (simd_src_out == {$past(simd_src[31]), 31'h0000_0000} && $past(simd_src[30:23]) == 8'h00))
    else $error("operand changed other than to signed zero of a denormal");
  AST_RES_TINY_ONLY: assert property (simd_op_valid |=> simd_result_out == $past(simd_raw_result) ||
    (simd_result_out == {$past(simd_raw_result[31]), 31'h0000_0000} &&
    $past(simd_raw_result[30:23]) < FP_EXP_MIN))
    else $error("result changed other than flush of an underflow");
  AST_BUSY_CAUSE: assert property ($rose(busy) |->
    $past(control_word_load_op || (reg_addr == OFF_SIMD && (reg_wr || reg_rd))))
    else $error("stall without load or SIMD register access");
  AST_BUSY_LEN: assert property ($fell(busy) |->
    busy_cnt_reg == SLOW_LOAD_CYCLES || busy_cnt_reg == SIMD_READ_CYCLES)
    else $error("stall length wrong");
  AST_OVF_NO_STALL: assert property (simd_op_valid && simd_overflow && !busy &&
    !control_word_load_op && !reg_wr && !reg_rd |=> !busy && simd_out_valid)
    else $error("masked overflow stalled the lane");
  AST_DIV_BOUND: assert property (div_start |-> ##[12:26] div_done)
    else $error("divide did not finish in time");
  AST_DIV_PULSE: assert property (div_done |=> !div_done)
    else $error("divide done longer than one cycle");
endmodule

bind fpmc_top fpmc_assertions chk_u (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .control_word_load_op, .simd_op_valid, .simd_src, .simd_raw_result, .simd_overflow,
  .div_start, .simd_src_out, .simd_result_out, .simd_out_valid, .div_done, .busy);

// [tb_fp_mode_denormal_control.sv]
// Self-checking bench for the floating-point mode control block
`timescale 1ns/1ps
module tb_fp_mode_denormal_control
  import fpmc_pkg::*;
;
  logic        ref_clk, srst, reg_wr, reg_rd, control_word_load_op, simd_op_valid;
  logic        simd_second_gen, simd_double, simd_overflow, div_start;
  logic        simd_out_valid, scalar_overflow, scalar_underflow, div_done, busy, irq;
  logic [3:0]  reg_addr;
  logic [15:0] load_value, scalar_exp, h0, h1, cur;
  logic [31:0] reg_wdata, reg_rdata, simd_src, simd_raw_result, simd_src_out;
  logic [31:0] simd_result_out, rd, w, e, s, r;
  int          n_errors, total_checks, n, slow_cnt, fast_cnt, d[3];
  logic [15:0] seq[20] = '{16'h037F, 16'h0C7F, 16'h037F, 16'h1F7F, 16'h037F, 16'h1F7F,
    16'h237F, 16'h037F, 16'h237F, 16'h037F, 16'h007F, 16'h027F, 16'h037F, 16'h007F,
    16'h027F, 16'h037F, 16'h0B7F, 16'h077F, 16'h0B7F, 16'h077F};
  logic [15:0] pv[3] = '{16'h007F, 16'h027F, 16'h037F};

  fpmc_top dut_u (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .control_word_load_op, .load_value, .simd_op_valid, .simd_second_gen, .simd_double,
    .simd_src, .simd_raw_result, .simd_overflow, .div_start, .scalar_exp, .simd_src_out,
    .simd_result_out, .simd_out_valid, .scalar_overflow, .scalar_underflow, .div_done,
    .busy, .irq);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Stall length is counted from the cycle after the strobe
  task automatic wait_idle(input int exp);
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n, exp);
  endtask

  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= wd;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    reg_op(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    wait_idle(a == OFF_SIMD ? SIMD_READ_CYCLES : 0);
  endtask

  // Expected path comes from a model of the last two loaded words
  task automatic load(input logic [15:0] v);
    logic fast;
    fast = (v == h0 || v == h1) && ((v ^ cur) & ~FAST_BITS_MASK) == 16'h0000;
    if (v != h0)
    begin
      h1 = h0;
      h0 = v;
    end
    cur = v;
    if (fast)
      fast_cnt++;
    else
      slow_cnt++;
    @(posedge ref_clk);
    control_word_load_op <= 1'b1;
    load_value           <= v;
    @(posedge ref_clk);
    control_word_load_op <= 1'b0;
    #1;
    wait_idle(fast ? 0 : SLOW_LOAD_CYCLES);
    rchk(OFF_SCW, {16'h0000, cur});
  endtask

  task automatic lane(input logic [1:0] g, input logic o, input logic [31:0] sv,
                      input logic [31:0] rv, input logic [31:0] es, input logic [31:0] er);
    @(posedge ref_clk);
    simd_op_valid                  <= 1'b1;
    {simd_second_gen, simd_double} <= g;
    simd_overflow                  <= o;
    simd_src                       <= sv;
    simd_raw_result                <= rv;
    @(posedge ref_clk);
    simd_op_valid <= 1'b0;
    #1;
    check(simd_out_valid, 1'b1);
    check(simd_src_out, es);
    check(simd_result_out, er);
    check(busy, 1'b0);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    srst = 1'b1;
    {reg_wr, reg_rd, control_word_load_op, simd_op_valid, div_start} = 5'h00;
    {simd_second_gen, simd_double, simd_overflow} = 3'h0;
    {reg_addr, load_value, scalar_exp} = 36'h0_0000_0000;
    {reg_wdata, simd_src, simd_raw_result} = 96'h0;
    {h0, h1, cur} = {3{SCW_RESET}};
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rchk(OFF_SCW, {16'h0000, SCW_RESET});
    rchk(OFF_SIMD, SIMD_RESET);
    rchk(OFF_IRQ_STATUS, 32'h0000_0000);
    rchk(OFF_STATS, 32'h0000_0000);
    rchk(4'hF, 32'h0000_0000);
    reg_op(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
    rchk(OFF_IRQ_MASK, 32'h0000_0001);
    load(16'h0C7F);
    check(irq, 1'b1);
    rchk(OFF_IRQ_STATUS, 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    check(irq, 1'b0);
    rchk(OFF_IRQ_STATUS, 32'h0000_0000);
    foreach (seq[i])
      load(seq[i]);
    for (int p = 0; p < 3; p++)
    begin
      load(pv[p]);
      @(posedge ref_clk);
      div_start <= 1'b1;
      @(posedge ref_clk);
      div_start <= 1'b0;
      #1;
      d[p] = 0;
      while (div_done !== 1'b1 && d[p] < 100)
      begin
        @(posedge ref_clk);
        #1;
        d[p]++;
      end
    end
    check(d[0], DIV_SINGLE_CYCLES);
    check(d[1] - d[0], DIV_DOUBLE_CYCLES - DIV_SINGLE_CYCLES);
    check(d[2] - d[1], DIV_EXT_CYCLES - DIV_DOUBLE_CYCLES);
    rchk(OFF_STATS, {slow_cnt[15:0], fast_cnt[15:0]});
    reg_op(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
    // Every enable combination, both generations and both precisions
    for (int m = 0; m < 4; m++)
    begin
      w = SIMD_RESET;
      w[FTZ_BIT] = m[0];
      w[DAZ_BIT] = m[1];
      reg_op(1'b1, OFF_SIMD, w);
      wait_idle(SERIALIZE_CYCLES);
      rchk(OFF_SIMD, w);
      for (int g = 0; g < 4; g++)
      begin
        s = {g[0], 31'h0040_0000};
        r = {g[1], 31'h0000_0001};
        lane(g[1:0], 1'b0, s, r, m[1] ? {g[0], 31'h0000_0000} : s,
             m[0] ? {g[1], 31'h0000_0000} : r);
      end
      lane(2'b00, 1'b1, 32'h3F80_0000, 32'h7F80_0000, 32'h3F80_0000, 32'h7F80_0000);
      check(irq, 1'b0);
      e = 32'h0000_0000;
      e[EV_SERIALIZE] = 1'b1;
      e[EV_FLUSH] = m[0];
      e[EV_DAZ] = m[1];
      rchk(OFF_IRQ_STATUS, e);
    end
    foreach (pv[i])
    begin
      @(posedge ref_clk);
      scalar_exp <= i == 0 ? 16'h5000 : (i == 1 ? 16'h0000 : 16'h7FFF);
      @(posedge ref_clk);
      #1;
      check({scalar_overflow, scalar_underflow}, i == 2 ? 2'b10 : (i == 1 ? 2'b01 : 2'b00));
    end
    // Register-bus write of the scalar word bypasses the load history
    reg_op(1'b1, OFF_SCW, 32'h0000_0C7F);
    rchk(OFF_SCW, 32'h0000_0C7F);
    end_sim();
  end
endmodule
